// *** src/csq_pkg.sv ***
// Constants, state encoding and carrier types of the card session sequencer
package csq_pkg;

  // ------------------------------------------------------------------
  // Clock and timing
  // ------------------------------------------------------------------
  localparam int unsigned CLK_MHZ      = 100;     // mclk rate in MHz
  localparam int unsigned STAB_MS      = 10;      // Wake/power-on settle
  localparam int unsigned STAB_CYC     = STAB_MS * 1000 * CLK_MHZ;
  localparam int unsigned RST_HOLD_CCK = 42000;   // Card clocks before RST
  localparam int unsigned ITV_DEF_CYC  = 200;     // Default interval length
  localparam int unsigned CNT_W        = 20;      // Settle counter width
  localparam int unsigned DW           = 16;      // Register data width
  localparam int unsigned AW           = 4;       // Register address width

  // ------------------------------------------------------------------
  // Register map (word index) and field positions
  // ------------------------------------------------------------------
  localparam logic [AW-1:0] REG_STATUS   = 4'h0;  // Read only
  localparam logic [AW-1:0] REG_FAULT    = 4'h1;  // Sticky, write 1 clears
  localparam logic [AW-1:0] REG_INTERVAL = 4'h2;  // Sequencer step length
  localparam int unsigned FLT_OC   = 0;           // Over-current
  localparam int unsigned FLT_OT   = 1;           // Over-temperature
  localparam int unsigned FLT_SUP  = 2;           // Card supply supervisor
  localparam int unsigned FLT_DET  = 3;           // Card removed
  localparam int unsigned FLT_W    = 4;
  localparam logic [DW-1:0] ITV_RST = 16'h00C8;   // Reset of REG_INTERVAL

  // ------------------------------------------------------------------
  // Sequencer states, one-hot
  // ------------------------------------------------------------------
  typedef enum logic [11:0] {
    ST_SETTLE  = 12'h001,
    ST_SLEEP   = 12'h002,
    ST_IDLE    = 12'h004,
    ST_ACT1    = 12'h008,
    ST_ACT2    = 12'h010,
    ST_ACT3    = 12'h020,
    ST_ACT4    = 12'h040,
    ST_SESSION = 12'h080,
    ST_DEA1    = 12'h100,
    ST_DEA2    = 12'h200,
    ST_DEA3    = 12'h400,
    ST_DEA4    = 12'h800
  } csq_state_t;

  // Register port request
  typedef struct packed {
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
    logic          wr;
    logic          rd;
  } csq_req_t;

  // Whole module state
  typedef struct packed {
    csq_state_t        state;
    logic [CNT_W-1:0]  cnt;
    logic [15:0]       hold;
    logic              rst_ok;
    logic              cmd_q;
    logic              fault;
    logic [FLT_W-1:0]  flags;
    logic [DW-1:0]     itv;
    logic [DW-1:0]     rdata;
    logic [2:0]        div;
    logic              clk_run;
    logic              cclk;
    logic              crst;
    logic              conv_en;
    logic              vsel;
    logic              io_rx;
    logic              lp;
    logic              osc_en;
    logic              irq_oe;
  } csq_regs_t;

endpackage

// *** src/csq_sequencer.sv ***
// Card session power sequencer: activation, deactivation, sleep, faults
//
// Added by the designer: the address-and-strobe port and the placing of the registers.
`timescale 1ns/100ps

module csq_sequencer #(
  parameter int unsigned STAB_CYCLES = csq_pkg::STAB_CYC,
  parameter int unsigned RST_HOLD    = csq_pkg::RST_HOLD_CCK
) (
  input  wire logic                    mclk,
  input  wire logic                    rst_b,
  input  wire logic [csq_pkg::AW-1:0]  reg_addr,
  input  wire logic [csq_pkg::DW-1:0]  reg_wdata,
  input  wire logic                    reg_wr,
  input  wire logic                    reg_rd,
  output logic      [csq_pkg::DW-1:0]  reg_rdata,
  input  wire logic                    activate_cmd_n,
  input  wire logic                    sleep_request,
  input  wire logic                    host_card_reset_in,
  input  wire logic                    card_detect,
  input  wire logic                    card_voltage_select,
  input  wire logic                    clk_ratio_sel_a,
  input  wire logic                    clk_ratio_sel_b,
  input  wire logic                    over_current,
  input  wire logic                    over_temp,
  input  wire logic                    card_supply_fault,
  input  wire logic                    card_supply_valid,
  output logic                         converter_en,
  output logic                         vcc_5v_sel,
  output logic                         io_rx_en,
  output logic                         card_clk,
  output logic                         card_rst,
  output logic                         low_power_state,
  output logic                         osc_en,
  output logic                         irq_n_out,
  output logic                         irq_n_oe
);

  // ------------------------------------------------------------------
  // Elaboration checks
  // ------------------------------------------------------------------
  if (STAB_CYCLES < 1 || STAB_CYCLES >= (1 << csq_pkg::CNT_W)) begin : g_c1
    $error("STAB_CYCLES does not fit the settle counter");
  end
  if (RST_HOLD < 1 || RST_HOLD > 65535) begin : g_c2
    $error("RST_HOLD does not fit the hold counter");
  end

  localparam logic [csq_pkg::CNT_W-1:0] STAB_LAST =
    csq_pkg::CNT_W'(STAB_CYCLES - 1);
  localparam logic [15:0] HOLD_N = 16'(RST_HOLD);

  csq_pkg::csq_req_t  req;
  csq_pkg::csq_regs_t r;
  csq_pkg::csq_regs_t n;
  logic               edge_act;
  logic               step_done;
  logic               in_seq;
  logic [csq_pkg::FLT_W-1:0] fault_now;
  logic               any_fault;
  logic               cmd_off;

  assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  // Half period of the card clock in mclk cycles minus one
  function automatic logic [2:0] half_last(input logic a, input logic b);
    if (a && !b) begin
      half_last = 3'h0;                 // Ratio 1: mclk/2 at best
    end else if (a && b) begin
      half_last = 3'h0;                 // Ratio 2
    end else if (b) begin
      half_last = 3'h1;                 // Ratio 4
    end else begin
      half_last = 3'h3;                 // Ratio 8
    end
  endfunction

  // Interval end: a zero length behaves as one cycle
  function automatic logic itv_end(input logic [csq_pkg::CNT_W-1:0] c,
                                   input logic [csq_pkg::DW-1:0] len);
    itv_end = (c[csq_pkg::DW-1:0] + 16'h0001 >= len);
  endfunction

  // Activation and session states, where faults count
  function automatic logic active_st(input csq_pkg::csq_state_t s);
    active_st = (s == csq_pkg::ST_ACT1) || (s == csq_pkg::ST_ACT2) ||
                (s == csq_pkg::ST_ACT3) || (s == csq_pkg::ST_ACT4) ||
                (s == csq_pkg::ST_SESSION);
  endfunction

  // ------------------------------------------------------------------
  // Event decode
  // ------------------------------------------------------------------
  // Falling edge of the activation command; a level low does not count
  assign edge_act  = r.cmd_q && !activate_cmd_n;
  assign step_done = itv_end(r.cnt, r.itv);
  assign in_seq    = active_st(r.state);
  assign cmd_off   = activate_cmd_n;
  // Supply supervisor only meaningful once the ramp interval has passed
  assign fault_now[csq_pkg::FLT_OC]  = over_current;
  assign fault_now[csq_pkg::FLT_OT]  = over_temp;
  assign fault_now[csq_pkg::FLT_SUP] = card_supply_fault &&
                                       (r.state != csq_pkg::ST_ACT1);
  assign fault_now[csq_pkg::FLT_DET] = !card_detect;
  assign any_fault = in_seq && (|fault_now);

  // ------------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------------
  always_comb begin
    n         = r;
    n.cmd_q   = activate_cmd_n;
    n.cnt     = r.cnt + 1'b1;
    n.rdata   = '0;

    // Sequencer
    case (r.state)
      csq_pkg::ST_SETTLE: begin
        // Edges here are swallowed; the host must toggle again
        if (r.cnt == STAB_LAST) begin
          n.state = csq_pkg::ST_IDLE;
        end
      end
      csq_pkg::ST_SLEEP: begin
        if (!sleep_request) begin
          n.state = csq_pkg::ST_SETTLE;
          n.cnt   = '0;
        end
      end
      csq_pkg::ST_IDLE: begin
        if (sleep_request && cmd_off) begin
          n.state = csq_pkg::ST_SLEEP;
        end else if (edge_act && card_detect) begin
          n.state   = csq_pkg::ST_ACT1;
          n.cnt     = '0;
          n.conv_en = 1'b1;
          n.vsel    = card_voltage_select;
          n.fault   = 1'b0;
        end
      end
      csq_pkg::ST_ACT1: begin
        if (step_done) begin
          n.cnt = '0;
          if (!card_supply_valid) begin
            n.state   = csq_pkg::ST_IDLE;
            n.conv_en = 1'b0;
            n.fault   = 1'b1;
          end else begin
            n.state = csq_pkg::ST_ACT2;
          end
        end
      end
      csq_pkg::ST_ACT2: begin
        // Reset input high holds the step open until it falls
        if (host_card_reset_in) begin
          n.cnt = '0;
        end else if (step_done) begin
          n.state = csq_pkg::ST_ACT3;
          n.cnt   = '0;
          n.io_rx = 1'b1;
        end
      end
      csq_pkg::ST_ACT3: begin
        if (step_done) begin
          n.state   = csq_pkg::ST_ACT4;
          n.cnt     = '0;
          n.clk_run = 1'b1;
          n.div     = '0;
          n.hold    = '0;
          n.rst_ok  = 1'b0;
        end
      end
      csq_pkg::ST_ACT4: begin
        if (step_done) begin
          n.state = csq_pkg::ST_SESSION;
        end
      end
      csq_pkg::ST_SESSION: begin
        n.cnt = '0;
      end
      csq_pkg::ST_DEA1: begin
        if (step_done) begin
          n.state = csq_pkg::ST_DEA2;
          n.cnt   = '0;
          n.crst  = 1'b0;
        end
      end
      csq_pkg::ST_DEA2: begin
        if (step_done) begin
          n.state   = csq_pkg::ST_DEA3;
          n.cnt     = '0;
          n.clk_run = 1'b0;
          n.cclk    = 1'b0;
        end
      end
      csq_pkg::ST_DEA3: begin
        if (step_done) begin
          n.state = csq_pkg::ST_DEA4;
          n.cnt   = '0;
          n.io_rx = 1'b0;
        end
      end
      csq_pkg::ST_DEA4: begin
        if (step_done) begin
          n.state   = csq_pkg::ST_IDLE;
          n.conv_en = 1'b0;
        end
      end
      default: begin
        n.state = csq_pkg::ST_SETTLE;
        n.cnt   = '0;
      end
    endcase

    // Host release or a fault abandons any step of activation
    if (in_seq && (cmd_off || any_fault)) begin
      n.state = csq_pkg::ST_DEA1;
      n.cnt   = '0;
      n.fault = r.fault || any_fault;
    end

    // Fault indication lives only while the host keeps the command low
    if (cmd_off && !in_seq) begin
      n.fault = 1'b0;
    end

    // Card clock divider, enable-style, stops low
    if (n.clk_run && r.clk_run) begin
      if (r.div >= half_last(clk_ratio_sel_a, clk_ratio_sel_b)) begin
        n.div  = '0;
        n.cclk = !r.cclk;
        if (!r.cclk && r.hold != HOLD_N) begin
          n.hold = r.hold + 16'h0001;
        end
      end else begin
        n.div = r.div + 3'h1;
      end
    end
    n.rst_ok = (r.hold == HOLD_N) && r.clk_run;

    // RST copies the host input once the hold count has run out
    if (r.state == csq_pkg::ST_SESSION &&
        n.state == csq_pkg::ST_SESSION) begin
      n.crst = host_card_reset_in && r.rst_ok;
    end

    // Analog power follows sleep
    n.lp     = (n.state == csq_pkg::ST_SLEEP);
    n.osc_en = !n.lp;

    // Interrupt line: low while settling, else low on card absence or fault
    if (n.state == csq_pkg::ST_SETTLE) begin
      n.irq_oe = 1'b1;
    end else begin
      n.irq_oe = !card_detect || n.fault;
    end

    // Sticky fault causes: set wins over a write-one clear
    if (req.wr && req.addr == csq_pkg::REG_FAULT) begin
      n.flags = r.flags & ~req.wdata[csq_pkg::FLT_W-1:0];
    end
    if (any_fault) begin
      n.flags = n.flags | fault_now;
    end
    if (req.wr && req.addr == csq_pkg::REG_INTERVAL) begin
      n.itv = req.wdata;
    end

    // Register read, answered the next cycle
    if (req.rd) begin
      if (req.addr == csq_pkg::REG_STATUS) begin
        n.rdata = {r.state, r.fault, r.lp, r.clk_run, card_detect};
      end else if (req.addr == csq_pkg::REG_FAULT) begin
        n.rdata = {{(csq_pkg::DW-csq_pkg::FLT_W){1'b0}}, r.flags};
      end else if (req.addr == csq_pkg::REG_INTERVAL) begin
        n.rdata = r.itv;
      end else begin
        n.rdata = '0;
      end
    end
  end

  // ------------------------------------------------------------------
  // State register; supervisor reset restarts the settle wait
  // ------------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      r         <= '0;
      r.state   <= csq_pkg::ST_SETTLE;
      r.cmd_q   <= 1'b1;
      r.itv     <= csq_pkg::ITV_RST;
      r.osc_en  <= 1'b1;
      r.irq_oe  <= 1'b1;
    end else begin
      r <= n;
    end
  end

  // ------------------------------------------------------------------
  // Outputs, all from flops except irq_n_out, which is a constant low
  // ------------------------------------------------------------------
  assign reg_rdata       = r.rdata;
  assign converter_en    = r.conv_en;
  assign vcc_5v_sel      = r.vsel;
  assign io_rx_en        = r.io_rx;
  assign card_clk        = r.cclk;
  assign card_rst        = r.crst;
  assign low_power_state = r.lp;
  assign osc_en          = r.osc_en;
  assign irq_n_out       = 1'b0;                       // Open drain pulls low
  assign irq_n_oe        = r.irq_oe;

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  AST_SUPPLY_OWNED: assert property (
    r.conv_en |-> !(r.state inside {csq_pkg::ST_SETTLE, csq_pkg::ST_SLEEP}))
    else $error("converter on outside a sequence");
  AST_OC_DEACT: assert property (
    (r.state == csq_pkg::ST_SESSION && over_current && !activate_cmd_n)
    ##1 !activate_cmd_n
    |-> (r.state == csq_pkg::ST_DEA1) && r.irq_oe ##1 r.irq_oe)
    else $error("over-current not acted on");
  AST_OT_FLAG: assert property (
    (in_seq && over_temp) |=> r.flags[csq_pkg::FLT_OT] && r.fault)
    else $error("over-temperature not flagged");
  AST_SLEEP_OFF: assert property (
    r.lp |-> !r.conv_en && !r.osc_en && !r.io_rx && !r.cclk)
    else $error("analog left on in sleep");
  AST_SLEEP_REFUSED: assert property (
    (r.state == csq_pkg::ST_IDLE && sleep_request && !activate_cmd_n)
    |=> !r.lp)
    else $error("sleep taken with command low");
  AST_SLEEP_DETECT: assert property (
    (r.state == csq_pkg::ST_SLEEP && sleep_request)
    |=> r.irq_oe == !$past(card_detect))
    else $error("presence lost in sleep");
  AST_SETTLE_BLOCK: assert property (
    (r.state == csq_pkg::ST_SETTLE && !activate_cmd_n) ##1 !activate_cmd_n
    |=> !r.conv_en)
    else $error("activation during settle");
  AST_VCC_CHECK: assert property (
    (r.state == csq_pkg::ST_ACT1 && step_done && !card_supply_valid &&
     !any_fault && !activate_cmd_n)
    |=> !r.conv_en && r.irq_oe)
    else $error("bad supply not shut off");
  AST_RX_BEFORE_CLK: assert property (
    $rose(r.clk_run) |-> r.io_rx && $past(r.io_rx))
    else $error("clock before reception");
  AST_RST_HOLD: assert property (
    $rose(r.crst) |-> $past(r.hold) == HOLD_N)
    else $error("card reset released early");
  AST_DEA_ORDER: assert property (
    (r.state == csq_pkg::ST_DEA3) |-> !r.crst && !r.cclk && r.conv_en)
    else $error("deactivation out of order");

  COV_SESSION:  cover property (r.state == csq_pkg::ST_SESSION && r.crst);
  COV_FAULT:    cover property (r.state == csq_pkg::ST_DEA1 && r.fault);
  COV_SLEEP:    cover property (r.lp ##1 !r.lp);
  COV_BAD_VCC:  cover property ((r.state == csq_pkg::ST_ACT1) ##1
                                (r.state == csq_pkg::ST_IDLE) && r.fault);

endmodule

// *** verification/csq_host_model.sv ***
// Host controller model driving the activation, sleep and card reset pins
`timescale 1ns/100ps

module csq_host_model (
  input  wire logic mclk,
  output logic      activate_cmd_n,
  output logic      sleep_request,
  output logic      host_card_reset_in
);
  // Idle host: command released, awake, card reset low
  initial begin
    activate_cmd_n     = 1'h1;
    sleep_request      = 1'h0;
    host_card_reset_in = 1'h0;
  end

  // Pins move only just after a rising edge, never on the far edge
  task automatic drive(input logic cmd_n, input logic slp, input logic rst);
    @(posedge mclk);
    activate_cmd_n     <= cmd_n;
    sleep_request      <= slp;
    host_card_reset_in <= rst;
  endtask

  // Command is edge taken: raise it first so a stale low never counts.
  // The bench calls this only with a card in the slot.
  task automatic activate(input logic rst);
    drive(1'h1, sleep_request, rst);
    drive(1'h0, sleep_request, rst);
  endtask
endmodule

// *** verification/csq_sequencer_tb.sv ***
// Self-checking bench for the card session sequencer
`timescale 1ns/100ps

module csq_sequencer_tb;
  // ------------------------------------------------------------
  // Signals, clock and instances
  // ------------------------------------------------------------
  localparam int STAB  = 50;   // Short settle keeps the run brief
  localparam int RHOLD = 20;   // Short card clock hold before RST
  localparam int L     = 4;    // Step length written to INTERVAL
  logic        mclk, rst_b, reg_wr, reg_rd, cd, csv, vsel, sel_a, sel_b;
  logic [3:0]  reg_addr, fv;
  logic [15:0] reg_wdata, reg_rdata;
  logic        act_n, slp, hrst, conv, vcc5, io_rx, cclk, crst;
  logic        lp, osc, irq_oe, irq_do, cdp, oc, ot, sf;
  logic [5:0]  ob;
  int          n_mismatch, compares;

  assign ob = {cclk, lp, irq_oe, crst, io_rx, conv};
  // Fault pins; fv[3] pulls the card out of the slot
  assign cdp = cd & ~fv[3];
  assign oc  = fv[0];
  assign ot  = fv[1];
  assign sf  = fv[2];

  // Free running 100 MHz clock
  initial begin
    mclk = 1'h0;
    forever #5 mclk = ~mclk;
  end

  csq_host_model i_host (.mclk(mclk), .activate_cmd_n(act_n),
    .sleep_request(slp), .host_card_reset_in(hrst));

  csq_sequencer #(.STAB_CYCLES(STAB), .RST_HOLD(RHOLD)) i_dut (
    .mclk(mclk), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .activate_cmd_n(act_n),
    .sleep_request(slp), .host_card_reset_in(hrst),
    .card_detect(cdp), .card_voltage_select(vsel),
    .clk_ratio_sel_a(sel_a), .clk_ratio_sel_b(sel_b),
    .over_current(oc), .over_temp(ot),
    .card_supply_fault(sf), .card_supply_valid(csv),
    .converter_en(conv), .vcc_5v_sel(vcc5), .io_rx_en(io_rx),
    .card_clk(cclk), .card_rst(crst), .low_power_state(lp),
    .osc_en(osc), .irq_n_out(irq_do), .irq_n_oe(irq_oe));

  // ------------------------------------------------------------
  // Check, wait and bus tasks
  // ------------------------------------------------------------
  task automatic final_report();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s exp %0h got %0h", nm, e, g);
    end
  endtask

  // Sample one step after the edge so its updates have landed
  task automatic tick();
    @(posedge mclk);
    #1;
  endtask

  // Bounded wait on one output; running out ends the run
  task automatic wait_bit(input int b, input logic v);
    for (int k = 0; k < 2000 && ob[b] !== v; k++) tick();
    if (ob[b] !== v) begin
      n_mismatch++;
      $display("CHECK FAILED wait bit %0d exp %0h got %0h", b, v, ob[b]);
      final_report();
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge mclk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'h1;
    @(posedge mclk);
    reg_wr <= 1'h0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd   <= 1'h1;
    @(posedge mclk);
    reg_rd <= 1'h0;
    #1 chk("reg_rdata", e, reg_rdata);
  endtask

  // Full session: activation, clock ratio, RST hold, deactivation
  task automatic sess(input logic [1:0] s, input logic rh);
    int k, n, p0;
    logic pv;
    @(posedge mclk);
    sel_a <= s[1];
    sel_b <= s[0];
    vsel  <= s[0];
    i_host.activate(rh);
    wait_bit(0, 1'h1);
    chk("vcc_5v_sel", s[0], vcc5);
    if (rh) begin
      repeat (6 * L) tick();
      chk("io_rx_en", 0, io_rx);
      i_host.drive(1'h0, 1'h0, 1'h0);
    end
    wait_bit(1, 1'h1);
    chk("card_clk", 0, cclk);
    i_host.drive(1'h0, 1'h1, 1'h1);
    n = 0;
    p0 = 0;
    pv = 1'h0;
    for (k = 0; k < 2000 && crst !== 1'h1; k++) begin
      tick();
      if (cclk === 1'h1 && pv === 1'h0) begin
        n++;
        if (n == 2) p0 = k;
        if (n == 3) chk("period", s == 0 ? 8 : s == 1 ? 4 : 2, k - p0);
      end
      pv = cclk;
    end
    chk("rst_hold", 1, n >= RHOLD && n <= RHOLD + 1);
    chk("card_rst", 1, crst);
    if (crst !== 1'h1) final_report();
    chk("low_power_state", 0, lp);
    i_host.drive(1'h1, 1'h0, 1'h1);
    wait_bit(2, 1'h0);
    wait_bit(0, 1'h0);
    i_host.drive(1'h1, 1'h0, 1'h0);
  endtask

  // Fault f raised mid-activation or in session, then logged and cleared
  task automatic flt(input int f);
    i_host.activate(1'h0);
    wait_bit(0, 1'h1);
    if (f == 0 || f == 2) wait_bit(1, 1'h1);
    if (f == 0) repeat (3 * L) tick(); // Over-current lands in session
    @(posedge mclk) fv <= 4'h1 << f;
    repeat (2) tick();
    chk("irq_n_oe fault", 1, irq_oe);
    wait_bit(0, 1'h0);
    @(posedge mclk) fv <= 4'h0;
    rd(4'h1, 16'h0001 << f);
    wr(4'h1, 16'h000F);
    rd(4'h1, 16'h0000);
    i_host.drive(1'h1, 1'h0, 1'h0);
    repeat (3) tick();
    chk("irq_n_oe idle", 0, irq_oe);
  endtask

  // Card lines may only be live in their nesting; sleep keeps converter and oscillator off
  always @(negedge mclk) begin
    if (rst_b === 1'h1) begin
      chk("nest", 0, (!io_rx && (crst || cclk)) || (!conv && io_rx));
      chk("sleep", 0, lp && (conv || osc));
      chk("irq_n_out", 0, irq_do);
    end
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    rst_b = 1'h0;
    {reg_wr, reg_rd} = 2'h0;
    sel_a = 1'h0;
    sel_b = 1'h0;
    vsel = 1'h0;
    {reg_addr, fv} = 8'h00;
    reg_wdata = 16'h0000;
    {cd, csv} = 2'h3;
    n_mismatch = 0;
    compares = 0;
    repeat (20) @(posedge mclk);
    rst_b <= 1'h1;
    i_host.activate(1'h0);
    i_host.drive(1'h1, 1'h0, 1'h0);
    repeat (STAB + 10) tick();
    chk("settle", 0, {conv, irq_oe});
    rd(4'h2, csq_pkg::ITV_RST);
    wr(4'h2, 16'h0004);
    rd(4'h2, 16'h0004);
    wr(4'h0, 16'hFFFF);
    rd(4'h0, {csq_pkg::ST_IDLE, 4'h1});
    rd(4'hF, 16'h0000);
    @(posedge mclk) fv <= 4'h7;
    repeat (3) tick();
    chk("idle fault", 0, {conv, irq_oe});
    @(posedge mclk) fv <= 4'h0;
    rd(4'h1, 16'h0000);
    for (int i = 0; i < 4; i++) sess(i[1:0], i == 1);
    for (int f = 0; f < 4; f++) flt(f);
    @(posedge mclk) csv <= 1'h0;
    i_host.activate(1'h0);
    wait_bit(0, 1'h1);
    wait_bit(0, 1'h0);
    chk("irq_n_oe supply", 1, irq_oe);
    @(posedge mclk) csv <= 1'h1;
    i_host.drive(1'h1, 1'h1, 1'h0);
    repeat (2) tick();
    chk("sleep", 16'h0002, {lp, osc});
    @(posedge mclk) cd <= 1'h0;
    repeat (2) tick();
    chk("irq_n_oe sleep", 1, irq_oe);
    @(posedge mclk) cd <= 1'h1;
    repeat (2) tick();
    chk("irq_n_oe sleep", 0, irq_oe);
    i_host.activate(1'h0);
    repeat (4) tick();
    chk("converter_en", 0, conv);
    i_host.drive(1'h1, 1'h0, 1'h0);
    repeat (2) tick();
    chk("irq_n_oe wake", 1, irq_oe);
    i_host.activate(1'h0);
    repeat (STAB) tick();
    chk("wake", 0, {conv, lp, irq_oe});
    sess(2'h0, 1'h0);
    i_host.activate(1'h0);
    wait_bit(1, 1'h1);
    @(posedge mclk) rst_b <= 1'h0;
    tick();
    chk("reset", 16'h0003, {conv, io_rx, cclk, crst, lp, osc, irq_oe});
    i_host.drive(1'h1, 1'h0, 1'h0);
    @(posedge mclk) rst_b <= 1'h1;
    repeat (STAB + 5) tick();
    rd(4'h2, csq_pkg::ITV_RST);
    chk("irq_n_oe", 0, irq_oe);
    final_report();
  end
endmodule
